// File: desc_rom_params.svh
`ifndef DESC_ROM_PARAMS_SVH
`define DESC_ROM_PARAMS_SVH

// ****************************************************************
// descriptor constants
// ****************************************************************
`define EP_LEN          8'h07
`define EP_TYPE         8'h05
`define EP_ADDR         8'h81
`define EP_ATTR         8'h03
`define EP_MPS_LO       8'h01
`define EP_MPS_HI       8'h00
`define EP_IVAL_HS      8'h0C
`define EP_IVAL_FS      8'hFF
`define OSC_LEN         8'h09
`define OSC_TYPE        8'h07
`define OSC_TOTAL_LO    8'h19
`define OSC_TOTAL_HI    8'h00
`define OSC_NUM_IF      8'h01
`define OSC_CFG_VAL     8'h01
`define OSC_CFG_STR     8'h00
`define ATTR_BUS_PWR    8'hA0
`define ATTR_SELF_PWR   8'hE0
`define IF_LEN          8'h09
`define IF_TYPE         8'h04
`define IF_NUM          8'h00
`define IF_ALT          8'h00
`define IF_NUM_EP       8'h01
`define IF_CLASS        8'h09
`define IF_SUBCLASS     8'h00
`define IF_PROTOCOL     8'h00
`define IF_STR          8'h00
`define ZERO_BYTE       8'h00
// remote wakeup bit of the attributes byte
`define ATTR_RWU_BIT    5
// ****************************************************************
// selection values
// ****************************************************************
`define SEL_EP_HS       2'h0
`define SEL_OSC_FS      2'h1
`define SEL_IF_FS       2'h2
`define SEL_EP_FS       2'h3

`endif

// File: desc_rom_pkg.sv
// ****************************************************************
// descriptor types
// ****************************************************************
package desc_rom_pkg;
  // which descriptor is being read
  typedef logic [1:0] desc_sel_t;
  // one descriptor byte
  typedef logic [7:0] desc_byte_t;
  // byte offset within a descriptor
  typedef logic [3:0] desc_off_t;
endpackage : desc_rom_pkg

// File: desc_byte_mux.sv
`timescale 1ns/1ps
`include "desc_rom_params.svh"

// ****************************************************************
// combinational byte table for all four descriptors
// ****************************************************************
module desc_byte_mux
  import desc_rom_pkg::*;
(
  input  wire desc_rom_pkg::desc_sel_t  sel,
  input  wire desc_rom_pkg::desc_off_t  offset,
  input  wire desc_rom_pkg::desc_byte_t cfg_attr,
  input  wire desc_rom_pkg::desc_byte_t cfg_power,
  output logic [7:0]                    data,
  output logic                          in_range
);

  // byte lookup per descriptor and offset
  always_comb
  begin
    data     = `ZERO_BYTE;
    in_range = 1'b1;
    case (sel)
      `SEL_EP_HS, `SEL_EP_FS:
      begin
        case (offset)
          4'h0:    data = `EP_LEN;
          4'h1:    data = `EP_TYPE;
          4'h2:    data = `EP_ADDR;
          4'h3:    data = `EP_ATTR;
          4'h4:    data = `EP_MPS_LO;
          4'h5:    data = `EP_MPS_HI;
          4'h6:    data = (sel == `SEL_EP_HS) ? `EP_IVAL_HS : `EP_IVAL_FS;
          default: in_range = 1'b0;
        endcase
      end
      `SEL_OSC_FS:
      begin
        case (offset)
          4'h0:    data = `OSC_LEN;
          4'h1:    data = `OSC_TYPE;
          4'h2:    data = `OSC_TOTAL_LO;
          4'h3:    data = `OSC_TOTAL_HI;
          4'h4:    data = `OSC_NUM_IF;
          4'h5:    data = `OSC_CFG_VAL;
          4'h6:    data = `OSC_CFG_STR;
          4'h7:    data = cfg_attr;
          4'h8:    data = cfg_power;
          default: in_range = 1'b0;
        endcase
      end
      default:
      begin
        case (offset)
          4'h0:    data = `IF_LEN;
          4'h1:    data = `IF_TYPE;
          4'h2:    data = `IF_NUM;
          4'h3:    data = `IF_ALT;
          4'h4:    data = `IF_NUM_EP;
          4'h5:    data = `IF_CLASS;
          4'h6:    data = `IF_SUBCLASS;
          4'h7:    data = `IF_PROTOCOL;
          4'h8:    data = `IF_STR;
          default: in_range = 1'b0;
        endcase
      end
    endcase
  end

endmodule : desc_byte_mux

// File: hub_descriptor_rom_single_tt.sv
`timescale 1ns/1ps
`include "desc_rom_params.svh"

// How it works
// - hs endpoint: 7 bytes, 81h, 03h, 1, 0Ch
// - fs endpoint same, interval FFh
// - endpoint attributes fixed at 03h
// - other-speed config: 09h, 07h, total 0019h
// - one interface, value 01h, string 00h
// - attributes A0h bus, E0h self powered
// - remote wakeup always advertised
// - max power picked by power source
// - max power in 2mA units, total draw
// - max power from loaded configuration data
// - fs interface: 09h, 04h, hub class

// ****************************************************************
// descriptor byte source: read request in, registered byte out
// ****************************************************************
module hub_descriptor_rom_single_tt
  import desc_rom_pkg::*;
(
  input  wire                           mclk,
  input  wire                           arst_n,
  input  wire                           rd_req,
  input  wire desc_rom_pkg::desc_sel_t  rd_sel,
  input  wire desc_rom_pkg::desc_off_t  rd_offset,
  input  wire                           power_source_select,
  input  wire desc_rom_pkg::desc_byte_t bus_powered_max_current,
  input  wire desc_rom_pkg::desc_byte_t self_powered_max_current,
  output logic                          rd_valid,
  output logic [7:0]                    rd_data,
  output logic                          rd_last,
  output logic                          rd_err
);

  // ****************************************************************
  // power dependent fields
  // ****************************************************************
  desc_byte_t attr_sel;     // attributes byte from power source
  desc_byte_t power_sel;    // max power byte, 2mA units
  logic [7:0] mux_data;     // looked up byte
  logic       mux_in_range; // offset inside descriptor
  logic       last_hit;     // offset is descriptor's last byte

  assign attr_sel  = power_source_select ? `ATTR_SELF_PWR
                                         : `ATTR_BUS_PWR;
  // loaded config value used as given, already in 2mA units
  assign power_sel = power_source_select ? self_powered_max_current
                                         : bus_powered_max_current;
  // values come from the loaded configuration ports

  // last byte of each descriptor
  assign last_hit = ((rd_sel == `SEL_EP_HS) || (rd_sel == `SEL_EP_FS))
                    ? (rd_offset == 4'h6) : (rd_offset == 4'h8);

  // byte table
  desc_byte_mux u_mux (
    .sel       (rd_sel),
    .offset    (rd_offset),
    .cfg_attr  (attr_sel),
    .cfg_power (power_sel),
    .data      (mux_data),
    .in_range  (mux_in_range)
  );

  // ****************************************************************
  // output registers
  // ****************************************************************
  // one-cycle answer to each request
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      rd_last  <= 1'b0;
      rd_err   <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_req;
      rd_data  <= rd_req ? mux_data : 8'h00;
      rd_last  <= rd_req & mux_in_range & last_hit;
      rd_err   <= rd_req & ~mux_in_range;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ep_ival;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h6 && rd_sel == `SEL_EP_HS)
      |=> (rd_data == 8'h0C);
  endproperty
  a_ep_ival: assert property (p_ep_ival)
    else $error("hs interval wrong");

  property p_fs_ival;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h6 && rd_sel == `SEL_EP_FS)
      |=> (rd_data == 8'hFF);
  endproperty
  a_fs_ival: assert property (p_fs_ival)
    else $error("fs interval wrong");

  property p_ep_attr;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h3 && rd_sel[0] == rd_sel[1])
      |=> (rd_data == 8'h03);
  endproperty
  a_ep_attr: assert property (p_ep_attr)
    else $error("endpoint attributes wrong");

  property p_osc_total;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h2 && rd_sel == `SEL_OSC_FS)
      |=> (rd_data == 8'h19);
  endproperty
  a_osc_total: assert property (p_osc_total)
    else $error("total length low byte wrong");

  property p_osc_cfg;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h5 && rd_sel == `SEL_OSC_FS)
      |=> (rd_data == 8'h01);
  endproperty
  a_osc_cfg: assert property (p_osc_cfg)
    else $error("configuration value wrong");

  property p_attr;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h7 && rd_sel == `SEL_OSC_FS)
      |=> (rd_data == ($past(power_source_select) ? 8'hE0 : 8'hA0));
  endproperty
  a_attr: assert property (p_attr)
    else $error("config attributes wrong");

  property p_rwu;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h7 && rd_sel == `SEL_OSC_FS)
      |=> rd_data[`ATTR_RWU_BIT];
  endproperty
  a_rwu: assert property (p_rwu)
    else $error("remote wakeup not advertised");

  property p_power;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h8 && rd_sel == `SEL_OSC_FS)
      |=> (rd_data == ($past(power_source_select)
                       ? $past(self_powered_max_current)
                       : $past(bus_powered_max_current)));
  endproperty
  a_power: assert property (p_power)
    else $error("max power wrong");

  property p_if_class;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h5 && rd_sel == `SEL_IF_FS)
      |=> (rd_data == 8'h09);
  endproperty
  a_if_class: assert property (p_if_class)
    else $error("interface class wrong");

  property p_mps_order;
    @(posedge mclk) disable iff (!arst_n)
    (rd_req && rd_offset == 4'h4 && rd_sel[0] == rd_sel[1])
      ##1 (rd_req && rd_offset == 4'h5 && rd_sel[0] == rd_sel[1])
      |=> (rd_data == 8'h00 && $past(rd_data) == 8'h01);
  endproperty
  a_mps_order: assert property (p_mps_order)
    else $error("max packet byte order wrong");

endmodule : hub_descriptor_rom_single_tt

// File: usb_host_model.sv
`timescale 1ns/1ps
// ****
// host side: issues descriptor byte reads
// ****
module usb_host_model
  import desc_rom_pkg::*;
(
  input  wire logic                     mclk,
  output desc_rom_pkg::desc_sel_t       rd_sel,
  output desc_rom_pkg::desc_off_t       rd_offset,
  output logic                          rd_req,
  input  wire logic                     rd_valid,
  input  wire desc_rom_pkg::desc_byte_t rd_data,
  input  wire logic                     rd_last,
  input  wire logic                     rd_err
);
  // idle lines at time zero
  initial
  begin
    rd_req    = 1'b0;
    rd_sel    = 2'h0;
    rd_offset = 4'h0;
  end

  // one read, entered just after an edge; answer taken one edge later
  task automatic read_byte(
    input  desc_sel_t  s,
    input  desc_off_t  o,
    input  bit         hold,
    output desc_byte_t d,
    output logic [2:0] f
  );
    rd_req    = 1'b1;
    rd_sel    = s;
    rd_offset = o;
    @(posedge mclk);
    #1;
    d = rd_data;
    f = {rd_valid, rd_last, rd_err};
    if (!hold)
    begin
      // released: leave no stale select or offset behind
      rd_req    = 1'b0;
      rd_sel    = ~s;
      rd_offset = ~o;
    end
  endtask : read_byte
endmodule : usb_host_model

// File: tb_hub_descriptor_rom_single_tt.sv
`timescale 1ns/1ps
module tb_hub_descriptor_rom_single_tt;
  import desc_rom_pkg::*;
  // ****
  // request rows beside expected answers
  // ****
  typedef struct {
    desc_sel_t  sel;
    desc_off_t  off;
    logic       psel;
    desc_byte_t data;
    logic [2:0] flags;
  } row_t;
  logic       mclk;
  logic       arst_n;
  logic       psel;
  desc_byte_t bus_cur;
  desc_byte_t self_cur;
  desc_sel_t  rd_sel;
  desc_off_t  rd_offset;
  logic       rd_req;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       rd_last;
  logic       rd_err;
  row_t       rows[$];
  int         failures;
  int         checks_done;
  desc_byte_t d;
  logic [2:0] f;
  // descriptor bytes, offset 0 leftmost
  logic [71:0] tbl [4] = '{72'h07_05_81_03_01_00_0C_00_00,
    72'h09_07_19_00_01_01_00_00_00, 72'h09_04_00_00_01_09_00_00_00,
    72'h07_05_81_03_01_00_FF_00_00};
  int         len [4] = '{7, 9, 9, 7};

  hub_descriptor_rom_single_tt dut (.mclk(mclk), .arst_n(arst_n),
    .rd_req(rd_req), .rd_sel(rd_sel), .rd_offset(rd_offset),
    .power_source_select(psel), .bus_powered_max_current(bus_cur),
    .self_powered_max_current(self_cur), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_last(rd_last), .rd_err(rd_err));
  usb_host_model host (.mclk(mclk), .rd_sel(rd_sel),
    .rd_offset(rd_offset), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_last(rd_last), .rd_err(rd_err));

  // expected answer worked out from the descriptor tables
  function automatic row_t mk(input desc_sel_t s, input desc_off_t o,
                              input logic p);
    row_t r;
    r = '{s, o, p, 8'h00, 3'b101};
    if (int'(o) < len[s])
    begin
      r.data  = tbl[s][71 - 8 * int'(o) -: 8];
      r.flags = {1'b1, int'(o) == len[s] - 1, 1'b0};
      if (s == 2'h1 && o == 4'h7)
        r.data = p ? 8'hE0 : 8'hA0;
      if (s == 2'h1 && o == 4'h8)
        r.data = p ? self_cur : bus_cur;
    end
    return r;
  endfunction : mk

  // compare and count
  task automatic chk(input string n, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // verdict and end of run
  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end

  // main sequence
  initial
  begin
    arst_n   = 1'b0;
    psel     = 1'b0;
    bus_cur  = 8'h32;
    self_cur = 8'h64;
    repeat (16) @(posedge mclk);
    chk("reset valid", rd_valid, 1'b0);
    #1 arst_n = 1'b1;
    // every byte plus one past the end, both power settings
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 2; p++)
        for (int o = 0; o <= len[s]; o++)
          rows.push_back(mk(s[1:0], o[3:0], p[0]));
    rows.push_back(mk(2'h0, 4'hF, 1'b0));
    // back-to-back stream
    foreach (rows[i])
    begin
      psel = rows[i].psel;
      host.read_byte(rows[i].sel, rows[i].off, i < rows.size() - 1, d, f);
      chk("data", d, rows[i].data);
      chk("flags", f, rows[i].flags);
    end
    @(posedge mclk);
    #1;
    chk("idle", {rd_valid, rd_data}, 9'h000);
    // freshly loaded power values
    bus_cur  = 8'h01;
    self_cur = 8'hFA;
    for (int p = 0; p < 2; p++)
    begin
      psel = p[0];
      host.read_byte(2'h1, 4'h8, 1'b0, d, f);
      chk("power", d, p ? 8'hFA : 8'h01);
      @(posedge mclk);
      #1;
    end
    // reset while an answer stands
    host.read_byte(2'h3, 4'h6, 1'b0, d, f);
    arst_n = 1'b0;
    #1;
    chk("mid reset", {rd_valid, rd_data}, 9'h000);
    @(posedge mclk);
    #1 arst_n = 1'b1;
    host.read_byte(2'h0, 4'h6, 1'b0, d, f);
    chk("after reset", d, 8'h0C);
    stop_test();
  end
endmodule : tb_hub_descriptor_rom_single_tt
